// ---- inc/pmam_pkg.sv ----
// Purpose: Constants for the address-match unit
// Assumes: APB with 32-bit data, one word per register
// Notes: Offsets are word aligned, so they are the byte addresses
package pmam_pkg;
  // Register offsets, used directly as byte addresses
  localparam logic [31:0] PMAM_IDX_BASE = 32'h0fffff6c;
  localparam logic [31:0] PMAM_IDX_MASK = 32'h0fffff7c;
  localparam logic [31:0] PMAM_ADR_BASE = PMAM_IDX_BASE;
  localparam logic [31:0] PMAM_ADR_MASK = PMAM_IDX_MASK;
  // Field positions
  localparam int PMAM_ADDR_HI = 27;
  localparam int PMAM_ADDR_LO = 2;
  localparam int PMAM_WE_BIT = 1;
  localparam int PMAM_RE_BIT = 0;
  localparam int PMAM_PKT_HIT_BIT = 1;
  // Reset values and write masks
  localparam logic [31:0] PMAM_BASE_RST = 32'h00000000;
  localparam logic [31:0] PMAM_MASK_RST = 32'h00000000;
  localparam logic [31:0] PMAM_BASE_WMASK = 32'h0ffffffc;
  localparam logic [31:0] PMAM_MASK_WMASK = 32'h0fffffff;
endpackage : pmam_pkg

// ---- hdl/pmam_top.sv ----
// Purpose: Programmable memory address match for power management
// Assumes: Processor cycle inputs are synchronous to pclk
// Notes: Hit drives bit 1 of the outgoing packet status
//   Bus answers at once, no wait states
//   Base reset value is zero
//
// Notes on behaviour
// - Base register holds word-aligned base address in bits 27:2.
// - Mask bit zero: base bit must equal processor address bit.
// - Mask bit one: that position always matches.
// - Write cycles compared only while mask bit 1 is set.
// - Read cycles compared only while mask bit 0 is set.
// - Enabled cycle that matches drives packet bit 1 high.
//
// The APB register port was chosen for this implementation.
`timescale 1ns/100ps
module pmam_top
  import pmam_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Processor memory cycle
  input wire logic cyc_valid,
  input wire logic cyc_write,
  input wire logic [31:0] cyc_addr,
  // Packet status
  output logic [7:0] pkt_status
);

  // Width of the compared address field
  localparam int FIELD_W = PMAM_ADDR_HI - PMAM_ADDR_LO + 1;

  // Register state
  logic [31:0] base_ff;
  logic [31:0] mask_ff;
  logic [31:0] prdata_ff;
  logic pslverr_ff;
  logic hit_ff;

  // Next register values
  logic [31:0] nxt_base;
  logic [31:0] nxt_mask;
  logic [31:0] nxt_prdata;
  logic nxt_pslverr;
  logic nxt_hit;

  // APB phase decode
  wire setup_phase;
  wire access_phase;
  wire rd_setup;
  wire wr_access;

  // Register offset decode
  wire sel_base;
  wire sel_mask;
  wire unmapped;

  // Write strobes
  wire wr_base;
  wire wr_mask;

  // Read select
  wire [31:0] rd_mux;

  // Compare path
  wire [FIELD_W-1:0] base_f;
  wire [FIELD_W-1:0] mask_f;
  wire [FIELD_W-1:0] addr_f;
  wire [FIELD_W-1:0] bit_ok;
  wire range_hit;

  // Cycle type
  wire wr_en;
  wire rd_en;
  wire type_ok;

  // Offset decode, shared by both registers
  function automatic logic reg_sel(
    input logic [31:0] adr,
    input logic [31:0] reg_adr
  );
    reg_sel = (adr == reg_adr);
  endfunction : reg_sel

  // Equal bits and masked bits both count as matching
  function automatic logic [FIELD_W-1:0] bit_match(
    input logic [FIELD_W-1:0] base_bits,
    input logic [FIELD_W-1:0] mask_bits,
    input logic [FIELD_W-1:0] addr_bits
  );
    bit_match = ~(base_bits ^ addr_bits) | mask_bits;
  endfunction : bit_match

  // Cycle type gate from the enable bits
  function automatic logic type_enabled(
    input logic wr_cycle,
    input logic wr_enable,
    input logic rd_enable
  );
    type_enabled = wr_cycle ? wr_enable : rd_enable;
  endfunction : type_enabled

  // Read word; unmapped offsets read zero
  function automatic logic [31:0] read_word(
    input logic base_hit,
    input logic mask_hit,
    input logic [31:0] base_word,
    input logic [31:0] mask_word
  );
    read_word = 32'h0;
    if (base_hit) begin
      read_word = base_word;
    end else if (mask_hit) begin
      read_word = mask_word;
    end
  endfunction : read_word

  // Packet status byte with only the hit bit used
  function automatic logic [7:0] pkt_byte(
    input logic hit
  );
    pkt_byte = 8'h00;
    pkt_byte[PMAM_PKT_HIT_BIT] = hit;
  endfunction : pkt_byte

  // APB phase decode
  assign setup_phase = psel & ~penable;
  assign access_phase = psel & penable;
  assign rd_setup = setup_phase & ~pwrite;
  assign wr_access = access_phase & pwrite;

  // Register offset decode
  assign sel_base = reg_sel(paddr, PMAM_ADR_BASE);
  assign sel_mask = reg_sel(paddr, PMAM_ADR_MASK);
  assign unmapped = ~(sel_base | sel_mask);

  // Write strobes
  assign wr_base = wr_access & sel_base;
  assign wr_mask = wr_access & sel_mask;

  // Write data, reserved bits dropped
  assign nxt_base = pwdata & PMAM_BASE_WMASK;
  assign nxt_mask = pwdata & PMAM_MASK_WMASK;

  // Read data captured in the setup cycle
  assign rd_mux = read_word(sel_base, sel_mask, base_ff, mask_ff);
  assign nxt_prdata = rd_setup ? rd_mux : prdata_ff;
  assign nxt_pslverr = setup_phase & unmapped;

  // Masked address compare, bits 27:2 only
  assign base_f = base_ff[PMAM_ADDR_HI:PMAM_ADDR_LO];
  assign mask_f = mask_ff[PMAM_ADDR_HI:PMAM_ADDR_LO];
  assign addr_f = cyc_addr[PMAM_ADDR_HI:PMAM_ADDR_LO];
  assign bit_ok = bit_match(base_f, mask_f, addr_f);
  assign range_hit = &bit_ok;

  // Cycle type gate
  assign wr_en = mask_ff[PMAM_WE_BIT];
  assign rd_en = mask_ff[PMAM_RE_BIT];
  assign type_ok = type_enabled(cyc_write, wr_en, rd_en);
  assign nxt_hit = cyc_valid & type_ok & range_hit;

  // Base register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_ff <= PMAM_BASE_RST;
    end else if (wr_base) begin
      base_ff <= nxt_base;
    end
  end

  // Mask register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_ff <= PMAM_MASK_RST;
    end else if (wr_mask) begin
      mask_ff <= nxt_mask;
    end
  end

  // Read data register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0;
    end else begin
      prdata_ff <= nxt_prdata;
    end
  end

  // Error flag for unmapped offsets
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_ff <= 1'b0;
    end else begin
      pslverr_ff <= nxt_pslverr;
    end
  end

  // Registered hit flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hit_ff <= 1'b0;
    end else begin
      hit_ff <= nxt_hit;
    end
  end

  // APB answer
  assign pready = 1'b1;
  assign prdata = prdata_ff;
  assign pslverr = pslverr_ff & access_phase;

  // Packet status
  assign pkt_status = pkt_byte(hit_ff);

endmodule : pmam_top

// ---- tb/pmam_peer.sv ----
// Purpose: companion model; Assumes: none; Notes: counts hit flags
`timescale 1ns/100ps
module pmam_peer (input wire logic pclk, input wire logic [7:0] pkt_status,
  output int hits = 0);
  always @(posedge pclk) hits += pkt_status[1] === 1'b1;
endmodule : pmam_peer

// ---- tb/pmam_sva.sv ----
// Purpose: checker; Assumes: APB writes seen; Notes: shadow registers
`timescale 1ns/100ps
module pmam_sva import pmam_pkg::*; (input wire logic pclk, presetn, psel,
  penable, pwrite, cyc_valid, cyc_write, input wire logic [31:0] paddr,
  pwdata, cyc_addr, input wire logic [7:0] pkt_status);
  logic [31:0] b_ff, m_ff;
  wire w = psel & penable & pwrite, f = pkt_status[1], c = cyc_write;
  wire e = m_ff[c];
  wire [31:0] d = (cyc_addr ^ b_ff) & PMAM_BASE_WMASK;
  wire h = cyc_valid & e & ~|(d & ~m_ff);
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) {b_ff, m_ff} <= '0;
    else if (w & paddr == PMAM_ADR_BASE) b_ff <= pwdata;
    else if (w & paddr == PMAM_ADR_MASK) m_ff <= pwdata;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_hit_on: assert property (h |=> f) else $error("miss");
  chk_hit_off: assert property (!h |=> !f) else $error("extra");
  chk_mask_dc: assert property (h & |d |=> f)
    else $error("mask");
  chk_wr_off: assert property (c & !e |=> !f) else $error("wr");
  chk_rd_off: assert property (!c & !e |=> !f) else $error("rd");
  chk_hit_src: assert property (f |-> $past(cyc_valid))
    else $error("src");
  cover property (h & c); cover property (h & !c); cover property (h & |d);
endmodule : pmam_sva
bind pmam_top pmam_sva u_pmam_sva (.*);

// ---- tb/testbench.sv ----
// Purpose: bench; Assumes: zero-wait APB; Notes: directed sequence
`timescale 1ns/100ps
module testbench import pmam_pkg::*;;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready;
  logic cyc_valid = 0, cyc_write = 0, pslverr;
  logic [31:0] paddr = 0, pwdata = 0, cyc_addr = 0, prdata;
  logic [7:0] pkt_status;
  int miscompares = 0, num_checks = 0, hits;
  always #20 pclk = ~pclk;
  pmam_top u_pmam_top (.*);
  pmam_peer u_pmam_peer (.*);
  task automatic chk(input logic [31:0] s, x);
    num_checks++;
    miscompares += s !== x;
    if (s !== x) $display("mismatch %0t %h %h", $time, s, x);
  endtask : chk
  task automatic apb(input logic w, input logic [31:0] a, d, x);
    @(posedge pclk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    if (!w) chk(prdata, x);
    chk(pslverr, (a != PMAM_ADR_BASE) && (a != PMAM_ADR_MASK));
    {psel, penable} <= 0;
  endtask : apb
  task automatic cyc(input logic w, input logic [31:0] a, input logic x);
    @(posedge pclk) {cyc_valid, cyc_write, cyc_addr} <= {1'b1, w, a};
    @(posedge pclk) cyc_valid <= 0;
    @(posedge pclk) chk(pkt_status, {x, 1'b0});
  endtask : cyc
  task automatic results(input int t);
    miscompares += t;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  initial #40000 results(1);
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1;
    apb(0, PMAM_ADR_MASK, 0, PMAM_MASK_RST);
    apb(1, PMAM_ADR_BASE, 32'h0ffffffc, 0);
    apb(0, PMAM_ADR_BASE, 0, PMAM_BASE_WMASK);
    apb(1, PMAM_ADR_BASE, 32'h01234560, 0);
    for (int i = 0; i < 4; i++) begin
      apb(1, PMAM_ADR_MASK, i, 0);
      for (int j = 0; j < 2; j++) cyc(j, 32'hf1234563, i[j]);
    end
    apb(1, PMAM_ADR_MASK, 32'h00000ffd, 0);
    apb(0, PMAM_ADR_MASK, 0, 32'h00000ffd);
    cyc(0, 32'h01234a9c, 1);
    cyc(1, 32'h01234a9c, 0);
    cyc(0, 32'h01236560, 0);
    apb(0, 32'h00000010, 0, 0);
    chk(hits, 5);
    results(0);
  end
endmodule : testbench
